// ---- core/dcp_pkg.sv ----
// Constants shared by the channel priority-set register block.
// Functional notes
// - Reading a channel bit returns 1 when that channel runs at high priority.
// - Reading a channel bit returns 0 when that channel runs at default priority.
// - Writing 1 to a set-register bit raises that channel to high priority.
// - Writing 0 to a set-register bit changes nothing; lowering uses the clear register.
// - Bit 9 is the first converter channel, present on one variant only.
// - Bits 8 to 4: converter output, two-wire master rx/tx, slave rx/tx.
// - Bits 3 to 0: serial port rx/tx, second SPI rx/tx.
// - Write-only clear register: writing 1 returns a channel to default priority.
// - Set register resets to zero; bits 31 to 12 are reserved.
package dcp_pkg;

  localparam int unsigned DATA_WIDTH    = 32;
  localparam int unsigned NUM_CHANNELS  = 12;

  // Byte addresses of the two registers
  localparam logic [31:0] PRIORITY_SET_OFFSET   = 32'h40010038;
  localparam logic [31:0] PRIORITY_CLEAR_OFFSET = 32'h4001003C;

  // Reset value of the priority mask
  localparam logic [11:0] PRIORITY_RESET = 12'h000;

  // Channel bit positions
  localparam int unsigned FILTER_RESULT_CHANNEL           = 11;
  localparam int unsigned SECOND_CONVERTER_CHANNEL        = 10;
  localparam int unsigned FIRST_CONVERTER_CHANNEL         = 9;
  localparam int unsigned DAC_CHANNEL                     = 8;
  localparam int unsigned TWOWIRE_MASTER_RECEIVE_CHANNEL  = 7;
  localparam int unsigned TWOWIRE_MASTER_TRANSMIT_CHANNEL = 6;
  localparam int unsigned TWOWIRE_SLAVE_RECEIVE_CHANNEL   = 5;
  localparam int unsigned TWOWIRE_SLAVE_TRANSMIT_CHANNEL  = 4;
  localparam int unsigned SERIAL_PORT_RECEIVE_CHANNEL     = 3;
  localparam int unsigned SERIAL_PORT_TRANSMIT_CHANNEL    = 2;
  localparam int unsigned SECOND_SPI_RECEIVE_CHANNEL      = 1;
  localparam int unsigned SECOND_SPI_TRANSMIT_CHANNEL     = 0;

  // Byte lanes that carry channel bits
  localparam logic [11:0] LANE0_BITS = 12'h0FF;
  localparam logic [11:0] LANE1_BITS = 12'hF00;

  // Bus phase of the register slave
  typedef enum logic [1:0] {
    DCP_ST_IDLE   = 2'b01,
    DCP_ST_ACCESS = 2'b10
  } dcp_phase_type;

endpackage

// ---- core/dcp_prio_bit.sv ----
// One channel's priority mask bit with set and clear requests.
`timescale 1ns/1ps
module dcp_prio_bit #(
  parameter bit PRESENT = 1'b1,
  parameter bit RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Requests
  input  wire logic set_req,
  input  wire logic clr_req,
  // State
  output logic      high_priority
);

  logic next_high_priority;

  always_comb begin
    next_high_priority = high_priority;
    if (!PRESENT) begin
      next_high_priority = 1'b0;
    end else if (set_req) begin
      next_high_priority = 1'b1;
    end else if (clr_req) begin
      next_high_priority = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_priority <= RESET_VALUE;
    end else begin
      high_priority <= next_high_priority;
    end
  end

endmodule // dcp_prio_bit

// ---- core/dcp_top.sv ----
// APB slave holding the per-channel high-priority mask of the DMA arbiter.
`timescale 1ns/1ps
module dcp_top #(
  parameter bit FIRST_CONVERTER_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Priority mask to the arbiter
  output logic      [11:0] high_priority_mask
);

  dcp_pkg::dcp_phase_type phase;
  dcp_pkg::dcp_phase_type next_phase;

  logic        set_hit;
  logic        clr_hit;
  logic        next_set_hit;
  logic        next_clr_hit;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setup_cycle;
  logic        commit_write;
  logic [11:0] lane_bits;
  logic [11:0] set_vec;
  logic [11:0] clr_vec;
  logic [11:0] mask_state;
  logic [11:0] read_mask;

  assign setup_cycle = psel && !penable;

  // Write takes effect only at the completing access edge
  assign commit_write = (phase == dcp_pkg::DCP_ST_ACCESS) && psel && penable
                        && pready && pwrite && !pslverr;

  assign lane_bits = (pstrb[0] ? dcp_pkg::LANE0_BITS : 12'h000)
                   | (pstrb[1] ? dcp_pkg::LANE1_BITS : 12'h000);

  // Only ones request a change; zeros leave the channel alone
  assign set_vec = (commit_write && set_hit) ? (pwdata[11:0] & lane_bits)
                                             : 12'h000;
  assign clr_vec = (commit_write && clr_hit) ? (pwdata[11:0] & lane_bits)
                                             : 12'h000;

  // One storage bit per channel; bit 9 exists only on one variant
  for (genvar i = 0; i < dcp_pkg::NUM_CHANNELS; i++) begin : g_chan
    localparam bit CH_PRESENT = (i == dcp_pkg::FIRST_CONVERTER_CHANNEL)
                                ? FIRST_CONVERTER_PRESENT : 1'b1;
    dcp_prio_bit #(
      .PRESENT     (CH_PRESENT),
      .RESET_VALUE (dcp_pkg::PRIORITY_RESET[i])
    ) u_bit (
      .pclk          (pclk),
      .presetn       (presetn),
      .set_req       (set_vec[i]),
      .clr_req       (clr_vec[i]),
      .high_priority (mask_state[i])
    );
  end

  assign high_priority_mask = mask_state;

  // Read view in channel order
  always_comb begin
    read_mask = 12'h000;
    read_mask[dcp_pkg::FILTER_RESULT_CHANNEL] =
      mask_state[dcp_pkg::FILTER_RESULT_CHANNEL];
    read_mask[dcp_pkg::SECOND_CONVERTER_CHANNEL] =
      mask_state[dcp_pkg::SECOND_CONVERTER_CHANNEL];
    read_mask[dcp_pkg::FIRST_CONVERTER_CHANNEL] =
      mask_state[dcp_pkg::FIRST_CONVERTER_CHANNEL];
    read_mask[dcp_pkg::DAC_CHANNEL] =
      mask_state[dcp_pkg::DAC_CHANNEL];
    read_mask[dcp_pkg::TWOWIRE_MASTER_RECEIVE_CHANNEL] =
      mask_state[dcp_pkg::TWOWIRE_MASTER_RECEIVE_CHANNEL];
    read_mask[dcp_pkg::TWOWIRE_MASTER_TRANSMIT_CHANNEL] =
      mask_state[dcp_pkg::TWOWIRE_MASTER_TRANSMIT_CHANNEL];
    read_mask[dcp_pkg::TWOWIRE_SLAVE_RECEIVE_CHANNEL] =
      mask_state[dcp_pkg::TWOWIRE_SLAVE_RECEIVE_CHANNEL];
    read_mask[dcp_pkg::TWOWIRE_SLAVE_TRANSMIT_CHANNEL] =
      mask_state[dcp_pkg::TWOWIRE_SLAVE_TRANSMIT_CHANNEL];
    read_mask[dcp_pkg::SERIAL_PORT_RECEIVE_CHANNEL] =
      mask_state[dcp_pkg::SERIAL_PORT_RECEIVE_CHANNEL];
    read_mask[dcp_pkg::SERIAL_PORT_TRANSMIT_CHANNEL] =
      mask_state[dcp_pkg::SERIAL_PORT_TRANSMIT_CHANNEL];
    read_mask[dcp_pkg::SECOND_SPI_RECEIVE_CHANNEL] =
      mask_state[dcp_pkg::SECOND_SPI_RECEIVE_CHANNEL];
    read_mask[dcp_pkg::SECOND_SPI_TRANSMIT_CHANNEL] =
      mask_state[dcp_pkg::SECOND_SPI_TRANSMIT_CHANNEL];
  end

  // Bus phase and answer, decided in the setup cycle
  always_comb begin
    next_phase   = phase;
    next_set_hit = set_hit;
    next_clr_hit = clr_hit;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (phase)
      dcp_pkg::DCP_ST_IDLE: begin
        if (setup_cycle) begin
          next_phase   = dcp_pkg::DCP_ST_ACCESS;
          next_set_hit = (paddr == dcp_pkg::PRIORITY_SET_OFFSET);
          next_clr_hit = (paddr == dcp_pkg::PRIORITY_CLEAR_OFFSET);
          next_pready  = 1'b1;
          next_pslverr = !((paddr == dcp_pkg::PRIORITY_SET_OFFSET)
                        || (paddr == dcp_pkg::PRIORITY_CLEAR_OFFSET));
          // Reserved bits and the write-only clear register read as zero
          if (!pwrite && (paddr == dcp_pkg::PRIORITY_SET_OFFSET)) begin
            next_prdata = {20'h00000, read_mask};
          end else begin
            next_prdata = 32'h00000000;
          end
        end
      end
      dcp_pkg::DCP_ST_ACCESS: begin
        if (psel && penable) begin
          next_phase   = dcp_pkg::DCP_ST_IDLE;
          next_set_hit = 1'b0;
          next_clr_hit = 1'b0;
        end else begin
          next_pready  = pready;
          next_pslverr = pslverr;
        end
      end
      default: begin
        next_phase   = dcp_pkg::DCP_ST_IDLE;
        next_set_hit = 1'b0;
        next_clr_hit = 1'b0;
        next_prdata  = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase   <= dcp_pkg::DCP_ST_IDLE;
      set_hit <= 1'b0;
      clr_hit <= 1'b0;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      phase   <= next_phase;
      set_hit <= next_set_hit;
      clr_hit <= next_clr_hit;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule // dcp_top

// ---- tb/dcp_top_assertions.sv ----
// Checker for the channel priority mask register block.
`timescale 1ns/1ps
module dcp_checker #(
  parameter bit FIRST_CONVERTER_PRESENT = 1'b1
) (
  // Clock, reset and APB
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic [3:0]  pstrb,
  // Mask to the arbiter
  input wire logic [11:0] high_priority_mask
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic        done = psel && penable && pready;
  wire logic        is_s = paddr == dcp_pkg::PRIORITY_SET_OFFSET;
  wire logic        is_c = paddr == dcp_pkg::PRIORITY_CLEAR_OFFSET;
  wire logic [11:0] m    = high_priority_mask;
  // Bit 9 has no storage on the variant without the first converter channel
  wire logic [11:0] wd   = pwdata[11:0] & {{4{pstrb[1]}}, {8{pstrb[0]}}}
                           & ~{2'b00, !FIRST_CONVERTER_PRESENT, 9'h000};
  property p_rd; done && !pwrite && is_s |-> prdata == {20'h0, m}; endproperty
  property p_set; done && pwrite && is_s |=> m == ($past(m) | $past(wd)); endproperty
  property p_zero; done && pwrite && is_s |=> ($past(m) & ~m) == 12'h000; endproperty
  property p_clr; done && pwrite && is_c |=> m == ($past(m) & ~$past(wd)); endproperty
  property p_hold; !(done && pwrite) |=> $stable(m); endproperty
  property p_rsv; pready |-> prdata[31:12] == 20'h0; endproperty
  property p_ans; psel && !penable |=> pready ##1 !pready; endproperty
  property p_err; done && !is_s && !is_c |-> pslverr && prdata == 32'h0; endproperty
  property p_absent; FIRST_CONVERTER_PRESENT || !m[9]; endproperty
  a_rd: assert property (p_rd) else $error("read data differs from mask");
  a_set: assert property (p_set) else $error("set write wrong");
  a_zero: assert property (p_zero) else $error("set write cleared a bit");
  a_clr: assert property (p_clr) else $error("clear write wrong");
  a_hold: assert property (p_hold) else $error("mask moved without write");
  a_rsv: assert property (p_rsv) else $error("upper read bits not zero");
  a_ans: assert property (p_ans) else $error("ready timing wrong");
  a_err: assert property (p_err) else $error("unmapped access not refused");
  a_absent: assert property (p_absent) else $error("absent channel bit set");
  c_set: cover property (done && pwrite && is_s);
  c_clr: cover property (done && pwrite && is_c);
  c_err: cover property (done && pslverr);
endmodule // dcp_checker

// ---- tb/testbench.sv ----
// Self-checking bench for the priority mask register block.
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic [11:0] hpm, m, d;
  logic [11:0] hpm_lean;
  logic [31:0] prdata_lean;
  logic        pready_lean, pslverr_lean;
  localparam logic [11:0] B9 = 12'h001 << dcp_pkg::FIRST_CONVERTER_CHANNEL;
  logic [32:0] q[$], e;
  int          err_total, checked, cyc, seed, i;
  localparam logic [31:0] S = dcp_pkg::PRIORITY_SET_OFFSET;
  localparam logic [31:0] C = dcp_pkg::PRIORITY_CLEAR_OFFSET;
  dcp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_priority_mask(hpm));
  // Variant without the first converter channel, fed the same bus
  dcp_top #(.FIRST_CONVERTER_PRESENT(1'b0)) i_dut_lean (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata_lean), .pready(pready_lean), .pslverr(pslverr_lean),
    .high_priority_mask(hpm_lean));
  task automatic stop_test;
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bad(input string s);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  // One APB transfer; notes the expected answer and updates the mask model
  task automatic apb(input logic w, input logic [31:0] a, wd, input logic [3:0] st);
    logic [11:0] v;
    v = wd[11:0] & {{4{st[1]}}, {8{st[0]}}};
    if (!w || (a != S && a != C)) q.push_back({a != S && a != C, (!w && a == S) ? {20'h0, m} : 32'h0});
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    if (w && a == S) m = m | v;
    if (w && a == C) m = m & ~v;
  endtask
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (++cyc > 6000) begin
      bad("timeout");
      stop_test();
    end
    if (psel && penable && pready && (!pwrite || pslverr)) begin
      e = q.size() ? q.pop_front() : 33'h1FFFFFFFF;
      checked++;
      if ({pslverr, prdata} !== e) bad("read data or error differs");
      if ({pslverr_lean, prdata_lean} !== (e & ~{21'h0, B9})) bad("lean read differs");
    end
    // Mask against the model, away from the edge at which a write commits
    if (presetn && !(psel && penable && pready)) begin
      checked++;
      if (hpm !== m) bad("priority mask differs from model");
      if (hpm_lean !== (m & ~B9)) bad("lean priority mask differs");
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    {m, err_total, checked, cyc} = 0;
    seed = 95;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, S, 0, 0);
    for (i = 0; i < 12; i++) begin
      apb(1, S, 32'h1 << i, 4'hF);
      apb(0, S, 0, 0);
      apb(1, C, 32'h1 << i, 4'hF);
    end
    apb(1, S, 32'hFFFFFFFF, 4'hF);
    apb(1, S, 0, 4'hF);
    apb(1, C, 32'hFFF, 4'h1);
    apb(0, S, 0, 0);
    apb(0, C, 0, 0);
    for (i = 0; i < 80; i++) begin
      d = 12'($random(seed));
      apb(d[0], d[2:1] == 0 ? 32'h40010040 : d[1] ? S : C, $random(seed), 4'($random(seed)));
    end
    @(posedge pclk);
    presetn <= 0;
    m <= 12'h000;
    @(posedge pclk);
    presetn <= 1;
    apb(0, S, 0, 0);
    stop_test();
  end
endmodule // testbench
bind dcp_top dcp_checker #(.FIRST_CONVERTER_PRESENT(FIRST_CONVERTER_PRESENT)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .high_priority_mask(high_priority_mask));
